// File: verilog/ext_tbl_pkg.sv
// Constants and types shared by the table write and wait controller.
// Assumes a single 250 MHz core clock; one instruction cycle is four clocks.
package ext_tbl_pkg;

    // ****************************************************************
    // Register byte offsets on the Avalon-MM slave
    // ****************************************************************
    localparam logic [4:0] OFS_MEM_CTRL = 5'h00;
    localparam logic [4:0] OFS_LATCH    = 5'h04;
    localparam logic [4:0] OFS_POINTER  = 5'h08;
    localparam logic [4:0] OFS_COMMAND  = 5'h0C;
    localparam logic [4:0] OFS_STATUS   = 5'h10;

    // ****************************************************************
    // Memory control fields and reset values
    // ****************************************************************
    localparam int         MC_MODE_LSB  = 0;
    localparam int         MC_WAIT_LSB  = 4;
    localparam int         MC_BUS8_BIT  = 7;
    localparam logic [1:0] MODE_WORD    = 2'h0;
    localparam logic [1:0] MODE_BSEL    = 2'h1;
    localparam logic [1:0] MODE_BYTE    = 2'h2;
    localparam logic [1:0] RST_MODE     = 2'h0;
    localparam logic [1:0] RST_WAIT     = 2'h3;

    // ****************************************************************
    // Command fields
    // ****************************************************************
    localparam int         CMD_WRITE_BIT = 0;
    localparam int         CMD_READ_BIT  = 1;
    localparam int         CMD_UPD_LSB   = 2;
    localparam logic [1:0] UPD_NONE      = 2'h0;
    localparam logic [1:0] UPD_POST_INC  = 2'h1;
    localparam logic [1:0] UPD_POST_DEC  = 2'h2;
    localparam logic [1:0] UPD_PRE_INC   = 2'h3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam logic [1:0] PH_Q1        = 2'h0;
    localparam logic [1:0] PH_Q2        = 2'h1;
    localparam logic [1:0] PH_Q3        = 2'h2;
    localparam logic [1:0] PH_Q4        = 2'h3;
    localparam int         TCY_NS       = 16;
    localparam int         CLK_NS       = 4;
    localparam int         CLK_PER_TCY  = TCY_NS / CLK_NS;

    typedef enum logic [1:0] {
        st_idle,
        st_opcode,
        st_data,
        st_fetch
    } state_t;

endpackage

// File: verilog/ext_tbl_lane_fmt.sv
// Byte lane and strobe formatter for one external table write.
// Pure combinational; the caller registers every result before the pins.
`timescale 1ns/10ps
`default_nettype none

module ext_tbl_lane_fmt (
    input  wire logic [1:0]  write_mode_field_i,
    input  wire logic        bus8_i,
    input  wire logic        ptr_lsb_i,
    input  wire logic [7:0]  table_latch_i,
    input  wire logic [7:0]  holding_i,
    output logic      [15:0] data_o,
    output logic             drive_o,
    output logic             write_high_strobe_o,
    output logic             write_low_strobe_o,
    output logic             upper_byte_select_o,
    output logic             lower_byte_select_o,
    output logic             capture_o
);

    always_comb begin
        data_o              = {table_latch_i, table_latch_i};
        drive_o             = 1'b1;
        write_high_strobe_o = 1'b0;
        write_low_strobe_o  = 1'b0;
        upper_byte_select_o = 1'b1;
        lower_byte_select_o = 1'b1;
        capture_o           = 1'b0;
        if (bus8_i) begin
            data_o             = {8'h00, table_latch_i};
            write_low_strobe_o = 1'b1;
        end else begin
            unique case (write_mode_field_i)
                ext_tbl_pkg::MODE_WORD: begin
                    if (!ptr_lsb_i) begin
                        // Even half only parks the byte; bus floats
                        drive_o   = 1'b0;
                        capture_o = 1'b1;
                    end else begin
                        data_o              = {table_latch_i, holding_i};
                        write_high_strobe_o = 1'b1;
                    end
                end
                ext_tbl_pkg::MODE_BSEL: begin
                    write_high_strobe_o = 1'b1;
                    upper_byte_select_o = ptr_lsb_i;
                    lower_byte_select_o = !ptr_lsb_i;
                end
                default: begin
                    // Byte write: both lanes carry the byte
                    write_high_strobe_o = ptr_lsb_i;
                    write_low_strobe_o  = !ptr_lsb_i;
                    upper_byte_select_o = ptr_lsb_i;
                    lower_byte_select_o = !ptr_lsb_i;
                end
            endcase
        end
    end

endmodule // ext_tbl_lane_fmt

`default_nettype wire

// File: verilog/ext_table_write_wait_ctrl.sv
// External memory bus controller for byte-wide table reads and writes,
// with programmable wait cycles. Assumes a synchronous 250 MHz clock and
// an Avalon-MM master for the registers; fetch requests come from a core.
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module ext_table_write_wait_ctrl (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Instruction fetch port
    input  wire logic        fetch_req_i,
    input  wire logic [20:0] fetch_addr_i,
    output logic             fetch_ack_o,
    output logic      [15:0] fetch_data_o,
    // External multiplexed bus
    input  wire logic [15:0] ad_i,
    output logic      [15:0] ad_o,
    output logic             ad_oe_o,
    output logic      [4:0]  addr_upper_o,
    output logic             ale_o,
    output logic             oe_n_o,
    output logic             write_high_strobe_n_o,
    output logic             write_low_strobe_n_o,
    output logic             upper_byte_select_n_o,
    output logic             lower_byte_select_n_o,
    output logic             byte_address_bit_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    ext_tbl_pkg::state_t state, next_state;
    logic [1:0]  phase, next_phase;
    logic [3:0]  wait_cnt, next_wait_cnt;
    logic        op_write, next_op_write;
    logic [7:0]  memory_control_reg, next_memory_control_reg;
    logic [7:0]  table_latch, next_table_latch;
    logic [20:0] table_pointer, next_table_pointer;
    logic [1:0]  upd_mode, next_upd_mode;
    logic [7:0]  holding, next_holding;
    logic [20:0] fetch_addr, next_fetch_addr;
    logic        rd_done, next_rd_done;
    logic [31:0] rdata, next_rdata;
    logic        fetch_ack, next_fetch_ack;
    logic [15:0] fetch_data, next_fetch_data;
    logic [15:0] pin_ad, next_pin_ad;
    logic        pin_ad_oe, next_pin_ad_oe;
    logic [4:0]  pin_upper, next_pin_upper;
    logic        pin_ale, next_pin_ale;
    logic        pin_oe_n, next_pin_oe_n;
    logic        pin_wrh_n, next_pin_wrh_n;
    logic        pin_wrl_n, next_pin_wrl_n;
    logic        pin_ub_n, next_pin_ub_n;
    logic        pin_lb_n, next_pin_lb_n;
    logic        pin_ba0, next_pin_ba0;

    logic [1:0]  write_mode_field;
    logic [1:0]  wait_field;
    logic        bus8;
    logic        busy;
    logic        wr_hit;
    logic [15:0] fmt_data;
    logic        fmt_drive;
    logic        fmt_wrh;
    logic        fmt_wrl;
    logic        fmt_ub;
    logic        fmt_lb;
    logic        fmt_capture;

    assign write_mode_field = memory_control_reg[ext_tbl_pkg::MC_MODE_LSB +: 2];
    assign wait_field       = memory_control_reg[ext_tbl_pkg::MC_WAIT_LSB +: 2];
    assign bus8             = memory_control_reg[ext_tbl_pkg::MC_BUS8_BIT];
    assign busy             = (state != ext_tbl_pkg::st_idle);

    // Pointer step shared by pre and post updates
    function automatic logic [20:0] ptr_step(input logic [20:0] p, input logic [1:0] m);
        logic [20:0] r;
        r = p;
        if (m == ext_tbl_pkg::UPD_POST_INC || m == ext_tbl_pkg::UPD_PRE_INC) begin
            r = p + 21'h000001;
        end else if (m == ext_tbl_pkg::UPD_POST_DEC) begin
            r = p - 21'h000001;
        end
        return r;
    endfunction

    ext_tbl_lane_fmt u_fmt (
        .write_mode_field_i  (write_mode_field),
        .bus8_i              (bus8),
        .ptr_lsb_i           (table_pointer[0]),
        .table_latch_i       (table_latch),
        .holding_i           (holding),
        .data_o              (fmt_data),
        .drive_o             (fmt_drive),
        .write_high_strobe_o (fmt_wrh),
        .write_low_strobe_o  (fmt_wrl),
        .upper_byte_select_o (fmt_ub),
        .lower_byte_select_o (fmt_lb),
        .capture_o           (fmt_capture)
    );

    // ****************************************************************
    // Register slave
    // ****************************************************************
    // Writes stall while a bus cycle runs so pointer and latch stay stable
    assign wr_hit            = avs_write_i && !busy;
    assign avs_waitrequest_o = (avs_write_i && busy) || (avs_read_i && !rd_done);
    assign avs_readdata_o    = rdata;

    always_comb begin
        next_rd_done = avs_read_i && !rd_done;
        next_rdata   = rdata;
        if (avs_read_i && !rd_done) begin
            unique case (avs_address_i)
                ext_tbl_pkg::OFS_MEM_CTRL: next_rdata = {24'h000000, memory_control_reg};
                ext_tbl_pkg::OFS_LATCH:    next_rdata = {24'h000000, table_latch};
                ext_tbl_pkg::OFS_POINTER:  next_rdata = {11'h000, table_pointer};
                ext_tbl_pkg::OFS_STATUS:   next_rdata = {16'h0000, holding, 7'h00, busy};
                default:                   next_rdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        next_state              = state;
        next_phase              = phase + 2'h1;
        next_wait_cnt           = wait_cnt;
        next_op_write           = op_write;
        next_memory_control_reg = memory_control_reg;
        next_table_latch        = table_latch;
        next_table_pointer      = table_pointer;
        next_upd_mode           = upd_mode;
        next_holding            = holding;
        next_fetch_addr         = fetch_addr;
        next_fetch_ack          = 1'b0;
        next_fetch_data         = fetch_data;

        if (wr_hit && avs_byteenable_i[0]) begin
            unique case (avs_address_i)
                ext_tbl_pkg::OFS_MEM_CTRL: next_memory_control_reg = avs_writedata_i[7:0];
                ext_tbl_pkg::OFS_LATCH:    next_table_latch = avs_writedata_i[7:0];
                ext_tbl_pkg::OFS_POINTER:  next_table_pointer[7:0] = avs_writedata_i[7:0];
                default: ;
            endcase
        end
        if (wr_hit && avs_address_i == ext_tbl_pkg::OFS_POINTER) begin
            if (avs_byteenable_i[1]) begin
                next_table_pointer[15:8] = avs_writedata_i[15:8];
            end
            if (avs_byteenable_i[2]) begin
                next_table_pointer[20:16] = avs_writedata_i[20:16];
            end
        end

        unique case (state)
            ext_tbl_pkg::st_idle: begin
                next_phase = ext_tbl_pkg::PH_Q1;
                if (wr_hit && avs_byteenable_i[0] && avs_address_i == ext_tbl_pkg::OFS_COMMAND
                    && (avs_writedata_i[ext_tbl_pkg::CMD_WRITE_BIT]
                        || avs_writedata_i[ext_tbl_pkg::CMD_READ_BIT])) begin
                    // A write command wins if both bits are set
                    next_state    = ext_tbl_pkg::st_opcode;
                    next_op_write = avs_writedata_i[ext_tbl_pkg::CMD_WRITE_BIT];
                    next_upd_mode = avs_writedata_i[ext_tbl_pkg::CMD_UPD_LSB +: 2];
                    if (avs_writedata_i[ext_tbl_pkg::CMD_UPD_LSB +: 2]
                        == ext_tbl_pkg::UPD_PRE_INC) begin
                        next_table_pointer = ptr_step(table_pointer, ext_tbl_pkg::UPD_PRE_INC);
                    end
                end else if (fetch_req_i && !fetch_ack) begin
                    // A request still held in its ack cycle is the one just served
                    next_state      = ext_tbl_pkg::st_fetch;
                    next_fetch_addr = fetch_addr_i;
                end
            end
            ext_tbl_pkg::st_opcode: begin
                // First instruction cycle of the table access has no bus work
                if (phase == ext_tbl_pkg::PH_Q4) begin
                    next_state = ext_tbl_pkg::st_data;
                end
            end
            ext_tbl_pkg::st_data: begin
                if (phase == ext_tbl_pkg::PH_Q3) begin
                    next_wait_cnt = 4'(wait_field * ext_tbl_pkg::CLK_PER_TCY);
                end else if (phase == ext_tbl_pkg::PH_Q4) begin
                    if (wait_cnt != 4'h0) begin
                        next_wait_cnt = wait_cnt - 4'h1;
                        next_phase    = phase;
                    end else begin
                        next_state = ext_tbl_pkg::st_idle;
                        // Single byte per access; no multi-word program sequence
                        if (op_write && fmt_capture) begin
                            next_holding = table_latch;
                        end
                        if (!op_write) begin
                            next_table_latch = (bus8 || !table_pointer[0]) ? ad_i[7:0]
                                                                           : ad_i[15:8];
                        end
                        if (upd_mode != ext_tbl_pkg::UPD_PRE_INC) begin
                            next_table_pointer = ptr_step(table_pointer, upd_mode);
                        end
                    end
                end
            end
            ext_tbl_pkg::st_fetch: begin
                // Fetches never stretch, whatever the wait field holds
                if (phase == ext_tbl_pkg::PH_Q4) begin
                    next_state      = ext_tbl_pkg::st_idle;
                    next_fetch_ack  = 1'b1;
                    next_fetch_data = ad_i;
                end
            end
        endcase
    end

    // ****************************************************************
    // Pin drive, one clock behind the sequencer
    // ****************************************************************
    always_comb begin
        logic [20:0] a;
        logic        active;
        a              = (state == ext_tbl_pkg::st_fetch) ? fetch_addr : table_pointer;
        active         = (state == ext_tbl_pkg::st_data) || (state == ext_tbl_pkg::st_fetch);
        next_pin_ad    = pin_ad;
        next_pin_ad_oe = 1'b0;
        next_pin_upper = a[20:16];
        next_pin_ale   = 1'b0;
        next_pin_oe_n  = 1'b1;
        next_pin_wrh_n = 1'b1;
        next_pin_wrl_n = 1'b1;
        next_pin_ub_n  = 1'b1;
        next_pin_lb_n  = 1'b1;
        next_pin_ba0   = a[0];
        if (active && phase == ext_tbl_pkg::PH_Q1) begin
            next_pin_ad    = a[15:0];
            next_pin_ad_oe = 1'b1;
            next_pin_ale   = 1'b1;
        end else if (active && op_write && state == ext_tbl_pkg::st_data) begin
            next_pin_ad    = fmt_data;
            next_pin_ad_oe = fmt_drive;
            next_pin_ub_n  = !fmt_ub;
            next_pin_lb_n  = !fmt_lb;
            next_pin_oe_n  = 1'b1;
            if (phase == ext_tbl_pkg::PH_Q3 || phase == ext_tbl_pkg::PH_Q4) begin
                next_pin_wrh_n = !fmt_wrh;
                next_pin_wrl_n = !fmt_wrl;
            end
        end else if (active) begin
            next_pin_ub_n = 1'b0;
            next_pin_lb_n = 1'b0;
            if (phase == ext_tbl_pkg::PH_Q3 || phase == ext_tbl_pkg::PH_Q4) begin
                next_pin_oe_n = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state              <= ext_tbl_pkg::st_idle;
            phase              <= ext_tbl_pkg::PH_Q1;
            wait_cnt           <= 4'h0;
            op_write           <= 1'b0;
            memory_control_reg <= 8'h00 | ({6'h00, ext_tbl_pkg::RST_WAIT} << ext_tbl_pkg::MC_WAIT_LSB)
                                        | {6'h00, ext_tbl_pkg::RST_MODE};
            table_latch        <= 8'h00;
            table_pointer      <= 21'h000000;
            upd_mode           <= ext_tbl_pkg::UPD_NONE;
            holding            <= 8'h00;
            fetch_addr         <= 21'h000000;
            rd_done            <= 1'b0;
            rdata              <= 32'h00000000;
            fetch_ack          <= 1'b0;
            fetch_data         <= 16'h0000;
            pin_ad             <= 16'h0000;
            pin_ad_oe          <= 1'b0;
            pin_upper          <= 5'h00;
            pin_ale            <= 1'b0;
            pin_oe_n           <= 1'b1;
            pin_wrh_n          <= 1'b1;
            pin_wrl_n          <= 1'b1;
            pin_ub_n           <= 1'b1;
            pin_lb_n           <= 1'b1;
            pin_ba0            <= 1'b0;
        end else begin
            state              <= next_state;
            phase              <= next_phase;
            wait_cnt           <= next_wait_cnt;
            op_write           <= next_op_write;
            memory_control_reg <= next_memory_control_reg;
            table_latch        <= next_table_latch;
            table_pointer      <= next_table_pointer;
            upd_mode           <= next_upd_mode;
            holding            <= next_holding;
            fetch_addr         <= next_fetch_addr;
            rd_done            <= next_rd_done;
            rdata              <= next_rdata;
            fetch_ack          <= next_fetch_ack;
            fetch_data         <= next_fetch_data;
            pin_ad             <= next_pin_ad;
            pin_ad_oe          <= next_pin_ad_oe;
            pin_upper          <= next_pin_upper;
            pin_ale            <= next_pin_ale;
            pin_oe_n           <= next_pin_oe_n;
            pin_wrh_n          <= next_pin_wrh_n;
            pin_wrl_n          <= next_pin_wrl_n;
            pin_ub_n           <= next_pin_ub_n;
            pin_lb_n           <= next_pin_lb_n;
            pin_ba0            <= next_pin_ba0;
        end
    end

    assign fetch_ack_o           = fetch_ack;
    assign fetch_data_o          = fetch_data;
    assign ad_o                  = pin_ad;
    assign ad_oe_o               = pin_ad_oe;
    assign addr_upper_o          = pin_upper;
    assign ale_o                 = pin_ale;
    assign oe_n_o                = pin_oe_n;
    assign write_high_strobe_n_o = pin_wrh_n;
    assign write_low_strobe_n_o  = pin_wrl_n;
    assign upper_byte_select_n_o = pin_ub_n;
    assign lower_byte_select_n_o = pin_lb_n;
    assign byte_address_bit_o    = pin_ba0;

endmodule // ext_table_write_wait_ctrl

`default_nettype wire

// File: testbench/ext_tbl_mem_model.sv
// External word memory on the multiplexed bus; logs each write it sees.
// Assumes registered, active low strobes from the controller.
`timescale 1ns/10ps
`default_nettype none
module ext_tbl_mem_model (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] ad_o,
    input  wire logic        oe_n_o,
    input  wire logic        write_high_strobe_n_o,
    input  wire logic        write_low_strobe_n_o,
    input  wire logic        upper_byte_select_n_o,
    input  wire logic        lower_byte_select_n_o,
    input  wire logic        byte_address_bit_o,
    output logic      [15:0] ad_i,
    output logic      [15:0] log_data,
    output logic      [3:0]  log_pins,
    output logic             log_ba,
    output logic      [7:0]  low_len,
    output logic      [7:0]  wr_cnt
);
    logic [15:0] junk = 16'h0000;
    logic [7:0]  cnt = 8'h00;
    logic        wr_act;
    assign wr_act = !write_high_strobe_n_o || !write_low_strobe_n_o;
    // Released bus toggles so a stale value never passes
    assign ad_i = !oe_n_o ? 16'hA55A : junk;
    always @(posedge core_clk_i) begin
        junk <= ~junk;
        cnt <= (wr_act || !oe_n_o) ? cnt + 8'h01 : 8'h00;
        if (!rst_n_i) begin
            low_len <= 8'h00;
            wr_cnt <= 8'h00;
        end else begin
            if (!wr_act && oe_n_o && cnt != 8'h00) low_len <= cnt;
            if (wr_act) begin
                log_data <= ad_o;
                log_pins <= {write_high_strobe_n_o, write_low_strobe_n_o,
                             upper_byte_select_n_o, lower_byte_select_n_o};
                log_ba <= byte_address_bit_o;
                if (cnt == 8'h00) wr_cnt <= wr_cnt + 8'h01;
            end
        end
    end
endmodule // ext_tbl_mem_model
`default_nettype wire

// File: testbench/ext_tbl_monitor.sv
// Pin timing checker for the table write controller.
// Bound to the top module; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ext_tbl_monitor (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] ad_o,
    input wire logic        ad_oe_o,
    input wire logic        ale_o,
    input wire logic        oe_n_o,
    input wire logic        write_high_strobe_n_o,
    input wire logic        write_low_strobe_n_o,
    input wire logic        byte_address_bit_o
);
    logic wr_n;
    assign wr_n = write_high_strobe_n_o & write_low_strobe_n_o;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_oe_in_write: assert property (!wr_n |-> oe_n_o)
        else $error("read strobe during write");
    a_one_strobe: assert property (write_high_strobe_n_o || write_low_strobe_n_o)
        else $error("both write strobes active");
    a_strobe_drive: assert property (!wr_n |-> ad_oe_o)
        else $error("write strobe with bus floating");
    a_write_phase: assert property ($fell(wr_n) |-> $past(ale_o, 2) && !ale_o)
        else $error("write strobe not in third quarter");
    a_read_phase: assert property ($fell(oe_n_o) |-> $past(ale_o, 2))
        else $error("read strobe not in third quarter");
    a_strobe_min: assert property ($fell(wr_n) |=> !wr_n)
        else $error("write strobe shorter than two clocks");
    a_data_hold: assert property (!wr_n && !$past(wr_n) |-> $stable(ad_o)
        && $stable(byte_address_bit_o))
        else $error("write data moved under strobe");
    a_ale_pulse: assert property (ale_o |=> !ale_o && oe_n_o && wr_n)
        else $error("address latch pulse malformed");
endmodule // ext_tbl_monitor
bind ext_table_write_wait_ctrl ext_tbl_monitor u_mon (.core_clk_i, .rst_n_i, .ad_o,
    .ad_oe_o, .ale_o, .oe_n_o, .write_high_strobe_n_o, .write_low_strobe_n_o,
    .byte_address_bit_o);
`default_nettype wire

// File: testbench/ext_table_write_wait_ctrl_tb.sv
// Register driven tests of table writes, reads, waits and fetches.
// Assumes the memory model on the external bus side.
`timescale 1ns/10ps
`default_nettype none
module ext_table_write_wait_ctrl_tb;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
    logic [3:0] avs_byteenable_i = 4'hF, log_pins;
    logic fetch_req_i = 1'b0, avs_waitrequest_o, fetch_ack_o, ad_oe_o, ale_o, oe_n_o;
    logic [20:0] fetch_addr_i = 21'h0;
    logic [15:0] fetch_data_o, ad_i, ad_o, log_data;
    logic [4:0] addr_upper_o;
    logic write_high_strobe_n_o, write_low_strobe_n_o, upper_byte_select_n_o;
    logic lower_byte_select_n_o, byte_address_bit_o, log_ba;
    logic [7:0] low_len, wr_cnt;
    int n_fail = 0, n_compared = 0;
    ext_table_write_wait_ctrl dut (.*);
    ext_tbl_mem_model mem (.*);
    always #2 core_clk_i = ~core_clk_i;
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task give_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task av(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk_i);
        avs_address_i <= a; avs_writedata_i <= d; avs_write_i <= w; avs_read_i <= !w;
        i = 0;
        do begin @(posedge core_clk_i); i++; end
        while (avs_waitrequest_o !== 1'b0 && i < 200);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0; avs_read_i <= 1'b0;
        if (i >= 200) begin n_fail++; give_verdict(); end
    endtask
    // ****************************************
    // Table operation, then poll until idle
    // ****************************************
    task top(input logic [20:0] p, input logic [7:0] l, input logic [3:0] c);
        int i;
        av(1'b1, ext_tbl_pkg::OFS_POINTER, {11'h0, p});
        av(1'b1, ext_tbl_pkg::OFS_LATCH, {24'h0, l});
        av(1'b1, ext_tbl_pkg::OFS_COMMAND, {28'h0, c});
        i = 0;
        do begin av(1'b0, ext_tbl_pkg::OFS_STATUS, 32'h0); i++; end
        while (rd[0] !== 1'b0 && i < 100);
        if (i >= 100) begin n_fail++; give_verdict(); end
        repeat (3) @(posedge core_clk_i);
        $display("test op at %h done", p);
    endtask
    initial begin
        int i, w;
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        av(1'b0, ext_tbl_pkg::OFS_MEM_CTRL, 32'h0); chk("mem_ctrl", rd, 32'h30);
        top(21'h100, 8'h11, 4'h1); chk("even_writes", wr_cnt, 32'h0);
        chk("even_hold", rd[15:8], 32'h11);
        top(21'h101, 8'h22, 4'h1); chk("odd_data", log_data, 32'h2211);
        chk("odd_pins", log_pins, 32'h4);
        chk("odd_ba", log_ba, 32'h1);
        chk("odd_len", low_len, 32'hE);
        for (w = 0; w < 3; w++) begin
            av(1'b1, ext_tbl_pkg::OFS_MEM_CTRL, w * 16 + 2);
            top(w, 8'h3C, 4'h1);
            chk("byte_data", log_data, 32'h3C3C);
            chk("byte_strobe", log_pins[3:2], w[0] ? 32'h1 : 32'h2);
            chk("byte_len", low_len, 2 + 4 * w);
        end
        av(1'b1, ext_tbl_pkg::OFS_MEM_CTRL, 32'h1); top(21'h200, 8'h5A, 4'h5);
        chk("bsel_data", log_data, 32'h5A5A);
        chk("bsel_pins", {log_pins, log_ba}, 32'hC);
        av(1'b0, ext_tbl_pkg::OFS_POINTER, 32'h0);
        chk("post_inc", rd, 32'h201);
        av(1'b1, ext_tbl_pkg::OFS_MEM_CTRL, 32'h82); top(21'h1, 8'h77, 4'hD);
        chk("bus8_strobe", log_pins[3:2], 32'h2);
        chk("bus8_data", log_data, 32'h77);
        chk("pre_inc_ba", log_ba, 32'h0);
        av(1'b0, ext_tbl_pkg::OFS_POINTER, 32'h0);
        chk("pre_inc", rd, 32'h2);
        av(1'b1, ext_tbl_pkg::OFS_MEM_CTRL, 32'h30); top(21'h3, 8'h00, 4'hA);
        av(1'b0, ext_tbl_pkg::OFS_LATCH, 32'h0); chk("read_latch", rd, 32'hA5);
        chk("read_len", low_len, 32'hE);
        av(1'b0, ext_tbl_pkg::OFS_POINTER, 32'h0);
        chk("post_dec", rd, 32'h2);
        @(posedge core_clk_i);
        fetch_addr_i <= 21'h40; fetch_req_i <= 1'b1;
        i = 0;
        do begin @(posedge core_clk_i); i++; end while (fetch_ack_o !== 1'b1 && i < 100);
        fetch_req_i <= 1'b0;
        if (i >= 100) begin n_fail++; give_verdict(); end
        repeat (3) @(posedge core_clk_i);
        chk("fetch_data", fetch_data_o, 32'hA55A);
        chk("fetch_len", low_len, 32'h2);
        av(1'b0, 5'h14, 32'h0); chk("unmapped", rd, 32'h0);
        $display("test fetch and unmapped done");
        give_verdict();
    end
endmodule // ext_table_write_wait_ctrl_tb
`default_nettype wire
